// ===== b3216_addr_xlat.sv
`timescale 1ns/1ps
`include "b3216_defs.svh"
// Byte enables and half select to low address bits and upper byte enable
module b3216_addr_xlat
    import b3216_pkg::*;
(
    input  wire logic [3:0] byte_en_n,
    input  wire logic       high_half,
    output logic            addr0,
    output logic            addr1,
    output logic            upper_byte_enable_n
);
    logic [1:0] lanes_n; // Active-low enables of the current half
    always_comb begin
        lanes_n = high_half ? byte_en_n[3:2] : byte_en_n[1:0];
        addr1 = high_half;
        // Even byte absent means odd-only access
        addr0 = lanes_n[0];
        upper_byte_enable_n = lanes_n[1];
    end
endmodule

// ===== b3216_bridge.sv
`timescale 1ns/1ps
`include "b3216_defs.svh"
// How it works
// - Write sends low half, then high
// - Read latches low half, then presents word
// - Transceiver direction follows write/read
// - Four enables from acknowledge; copro-bound ones also need byte enables
// - Two commands per 32-bit transfer
// - Counter starts on select and cycle
// - Half ready clears the counter
// - Byte enables become address, upper enable
// - First ready bumps bit one, latches on a read
// - Host ready only after second half
// - Cycle active from strobes until ready
// - Second half reissues command, keeps select
// - Second read half drives both host halves
// - Write drives low then high half
module b3216_bridge
    import b3216_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        address_strobe_n,     // Host address strobe
    input  wire logic        data_enable_strobe_n, // Host data enable
    input  wire logic        copro_select,         // Address decode hit
    input  wire logic        write_not_read,       // High for host write
    input  wire logic [3:0]  byte_en_n,            // Host byte enables
    input  wire logic [31:0] host_wdata,           // Host write word
    input  wire logic [15:0] copro_rdata,          // Coprocessor read data
    input  wire logic        slave_acknowledge,    // Coprocessor busy with access
    output logic [31:0]      host_rdata,           // Assembled read word
    output logic [15:0]      copro_wdata,          // Half toward coprocessor
    output logic             host_ready_n,         // Ready to host, low active
    output logic             copro_cs_n,
    output logic             copro_rd_n,
    output logic             copro_wr_n,
    output logic             copro_mem_sel,        // Memory, not IO
    output logic             addr0,
    output logic             addr1,
    output logic             upper_byte_enable_n,
    output logic             to_copro_dir,         // High: host to coprocessor
    output logic             low_half_to_copro_en,
    output logic             low_half_to_host_en,
    output logic             high_half_to_copro_en,
    output logic             high_half_to_host_en,
    output logic             low_latch_clk         // Captures first read half
);
    b3216_state_e       state_q;       // Current half
    logic               cycle_active_q;// Host cycle under way
    logic               wr_q;          // Direction latched at start
    logic [15:0]        low_q;         // Captured first read half
    logic               latch_q;       // Latch clock pulse
    logic               ready_q;       // Ready pulse to host
    logic               cmd_active;    // Command window from controller
    logic               half_ready;    // Internal half-transfer ready
    logic               half_req;      // A half is being requested
    logic               high_half;     // Second half is active
    logic [1:0]         lanes;         // Active-high lanes of the half
    always_ff @(posedge ref_clk) begin
        if (rst || ready_q) begin
            cycle_active_q <= 1'b0;
        end else if (!address_strobe_n && !data_enable_strobe_n) begin
            cycle_active_q <= 1'b1;
        end
    end
    // Latch direction when the cycle begins; bursts unsupported
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wr_q <= 1'b0;
        end else if (state_q == B3216_IDLE) begin
            wr_q <= write_not_read;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_q <= B3216_IDLE;
        end else begin
            unique case (state_q)
                B3216_IDLE: begin
                    if (cycle_active_q && copro_select) begin
                        state_q <= B3216_LOW;
                    end
                end
                B3216_LOW: begin
                    if (half_ready) begin
                        state_q <= B3216_HIGH;
                    end
                end
                B3216_HIGH: begin
                    if (half_ready) begin
                        state_q <= B3216_DONE;
                    end
                end
                B3216_DONE: begin
                    state_q <= B3216_IDLE;
                end
            endcase
        end
    end
    assign half_req  = (state_q == B3216_LOW) || (state_q == B3216_HIGH);
    assign high_half = (state_q == B3216_HIGH);
    b3216_cmd_ctrl u_cmd (
        .ref_clk           (ref_clk),
        .rst               (rst),
        .half_req          (half_req),
        .slave_acknowledge (slave_acknowledge),
        .cmd_active        (cmd_active),
        .half_ready        (half_ready)
    );
    b3216_addr_xlat u_xlat (
        .byte_en_n           (byte_en_n),
        .high_half           (high_half),
        .addr0               (addr0),
        .addr1               (addr1),
        .upper_byte_enable_n (upper_byte_enable_n)
    );
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            latch_q <= 1'b0;
            low_q   <= `B3216_HALF_ZERO;
        end else begin
            latch_q <= half_ready && (state_q == B3216_LOW) && !wr_q;
            if (slave_acknowledge && (state_q == B3216_LOW) && !wr_q) begin
                low_q <= copro_rdata;
            end
        end
    end
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            host_rdata <= {`B3216_HALF_ZERO, `B3216_HALF_ZERO};
        end else if (slave_acknowledge && high_half && !wr_q) begin
            host_rdata <= {copro_rdata, low_q};
        end
    end
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            copro_wdata <= `B3216_HALF_ZERO;
        end else if (state_q == B3216_IDLE || half_ready) begin
            copro_wdata <= (half_ready && state_q == B3216_LOW) ?
                           host_wdata[31:16] : host_wdata[15:0];
        end
    end
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ready_q <= 1'b0;
        end else begin
            ready_q <= half_ready && high_half;
        end
    end
    // Command and select pins
    always_comb begin
        copro_cs_n    = !half_req;
        copro_rd_n    = !(cmd_active && !wr_q);
        copro_wr_n    = !(cmd_active && wr_q);
        copro_mem_sel = half_req;
        host_ready_n  = !ready_q;
        low_latch_clk = latch_q;
        to_copro_dir  = wr_q;
        lanes = high_half ? ~byte_en_n[3:2] : ~byte_en_n[1:0];
    end
    always_comb begin
        low_half_to_copro_en  = slave_acknowledge && wr_q && !high_half
                                && (state_q == B3216_LOW) && (|lanes);
        high_half_to_copro_en = slave_acknowledge && wr_q && high_half && (|lanes);
        low_half_to_host_en   = slave_acknowledge && !wr_q && high_half;
        high_half_to_host_en  = slave_acknowledge && !wr_q && high_half;
    end
endmodule

// ===== b3216_checker.sv
`timescale 1ns/1ps
// Port-level watch on the bridge; sees only the top module's pins
module b3216_checker (
    input wire logic       ref_clk,
    input wire logic       rst,
    input wire logic [3:0] byte_en_n,
    input wire logic       slave_acknowledge,
    input wire logic       host_ready_n,
    input wire logic       copro_cs_n,
    input wire logic       copro_rd_n,
    input wire logic       copro_wr_n,
    input wire logic       copro_mem_sel,
    input wire logic       addr0,
    input wire logic       upper_byte_enable_n,
    input wire logic       to_copro_dir,
    input wire logic       low_half_to_copro_en,
    input wire logic       low_half_to_host_en,
    input wire logic       high_half_to_host_en,
    input wire logic       low_latch_clk
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    ready_pulse_a: assert property ($fell(host_ready_n) |=> host_ready_n)
        else $error("host ready held too long");
    ready_after_ack_a: assert property ($fell(host_ready_n) |-> !slave_acknowledge)
        else $error("host ready during an access");
    one_cmd_a: assert property (!(!copro_rd_n && !copro_wr_n))
        else $error("read and write command together");
    dir_write_a: assert property (!copro_wr_n |-> to_copro_dir)
        else $error("write command with host-bound direction");
    dir_read_a: assert property (!copro_rd_n |-> !to_copro_dir)
        else $error("read command with copro-bound direction");
    cmd_select_a: assert property ((!copro_rd_n || !copro_wr_n) |-> !copro_cs_n && copro_mem_sel)
        else $error("command without select");
    enable_ack_a: assert property ((low_half_to_copro_en || high_half_to_host_en) |-> slave_acknowledge)
        else $error("transceiver enabled without acknowledge");
    full_word_addr_a: assert property (!copro_cs_n && byte_en_n == 4'h0 |-> !addr0 && !upper_byte_enable_n)
        else $error("full word gives wrong low address");
    both_host_a: assert property (high_half_to_host_en && byte_en_n == 4'h0 |-> low_half_to_host_en)
        else $error("second read half misses low enable");
    latch_read_a: assert property (low_latch_clk |-> !to_copro_dir)
        else $error("latch pulse on a write");
    write_low_a: assert property (low_half_to_copro_en |-> to_copro_dir)
        else $error("low copro enable on a read");
    cover property (!copro_wr_n ##[1:60] $fell(host_ready_n));
    cover property (!copro_rd_n ##[1:60] $fell(host_ready_n));
    cover property (low_latch_clk);
endmodule
bind b3216_bridge b3216_checker i_chk (.*);

// ===== b3216_cmd_ctrl.sv
`timescale 1ns/1ps
`include "b3216_defs.svh"
// Counts cycles per half and issues one command each time
module b3216_cmd_ctrl
    import b3216_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic half_req,
    input  wire logic slave_acknowledge,
    output logic      cmd_active,
    output logic      half_ready
);
    logic [`B3216_CNT_W-1:0] cnt_q;  // Cycles since the half began
    logic                    ack_seen_q; // Acknowledge observed this half
    logic                    ack_q;  // Acknowledge one cycle ago
    always_ff @(posedge ref_clk) begin
        if (rst || half_ready || !half_req) begin
            cnt_q <= `B3216_CNT_ZERO;
        end else if (cnt_q != `B3216_CMD_DELAY_CYC) begin
            cnt_q <= cnt_q + `B3216_CNT_ONE;
        end
    end
    // Track acknowledge so its fall ends the half
    always_ff @(posedge ref_clk) begin
        if (rst || half_ready) begin
            ack_seen_q <= 1'b0;
        end else if (slave_acknowledge && cmd_active) begin
            ack_seen_q <= 1'b1;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= slave_acknowledge;
        end
    end
    // Command holds until the coprocessor's acknowledge is first seen
    assign cmd_active = half_req && (cnt_q == `B3216_CMD_DELAY_CYC) && !ack_seen_q;
    assign half_ready = ack_seen_q && ack_q && !slave_acknowledge;
endmodule

// ===== b3216_copro_model.sv
`timescale 1ns/1ps
// Coprocessor slave port: one acknowledge window per command
module b3216_copro_model (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic [3:0]  busy_cyc,   // Graphics work still pending
    input  wire logic [31:0] rd_word,    // Word served on reads
    input  wire logic        copro_rd_n,
    input  wire logic        copro_wr_n,
    input  wire logic        addr1,
    input  wire logic [15:0] copro_wdata,
    output logic             slave_acknowledge,
    output logic [15:0]      copro_rdata,
    output logic [31:0]      got_word,   // Halves written, by half
    output logic [1:0]       got_a1,     // Address bit one per half
    output logic [7:0]       halves      // Completed halves
);
    logic hi;
    initial begin
        slave_acknowledge = 1'b0;
        copro_rdata = 16'h0000;
        got_word = 32'h00000000;
        got_a1 = 2'h0;
        halves = 8'h00;
        hi = 1'b0;
        forever begin
            @(posedge ref_clk);
            if (rst) hi = 1'b0;
            else if (!copro_rd_n || !copro_wr_n) begin
                repeat (busy_cyc) @(posedge ref_clk);
                slave_acknowledge <= 1'b1;
                copro_rdata <= hi ? rd_word[31:16] : rd_word[15:0];
                @(posedge ref_clk);
                got_word[hi*16 +: 16] = copro_wdata;
                got_a1[hi] = addr1;
                @(posedge ref_clk);
                slave_acknowledge <= 1'b0;
                // Stale data is inverted once acknowledge drops
                copro_rdata <= ~copro_rdata;
                halves <= halves + 8'h01;
                hi = ~hi;
            end
        end
    end
endmodule

// ===== b3216_defs.svh
`ifndef B3216_DEFS_SVH
`define B3216_DEFS_SVH
// Cycles from start of a half until the command is driven
`define B3216_CMD_DELAY_NS   20
`define B3216_CMD_DELAY_CYC  (4'((`B3216_CMD_DELAY_NS + 9) / 10))
`define B3216_CNT_W          4
`define B3216_HALF_W         16
`define B3216_WORD_W         32
`define B3216_BE_W           4
`define B3216_CNT_ZERO       4'h0
`define B3216_CNT_ONE        4'h1
`define B3216_HALF_ZERO      16'h0000
`define B3216_BE_NONE        4'hF
`endif

// ===== b3216_pkg.sv
package b3216_pkg;
    // Bridge sequencing states, Gray coded along the usual path
    typedef enum logic [1:0] {
        B3216_IDLE  = 2'b00,
        B3216_LOW   = 2'b01,
        B3216_HIGH  = 2'b11,
        B3216_DONE  = 2'b10
    } b3216_state_e;
endpackage

// ===== testbench.sv
`timescale 1ns/1ps
module testbench;
    logic ref_clk, rst, address_strobe_n, data_enable_strobe_n, copro_select, write_not_read;
    logic [3:0] byte_en_n, busy_cyc;
    logic [31:0] host_wdata, host_rdata, rd_word, got_word;
    logic [15:0] copro_rdata, copro_wdata;
    logic slave_acknowledge, host_ready_n, copro_cs_n, copro_rd_n, copro_wr_n, copro_mem_sel;
    logic addr0, addr1, upper_byte_enable_n, to_copro_dir, low_latch_clk;
    logic low_half_to_copro_en, low_half_to_host_en, high_half_to_copro_en, high_half_to_host_en;
    logic [1:0] got_a1;
    logic [7:0] halves;
    int fail_count = 0, num_checks = 0;
    // Rows: wait cycles, write flag, word
    logic [36:0] rows [6] = '{{4'h0, 1'b1, 32'h1234ABCD}, {4'h0, 1'b0, 32'h5A5A0FF0},
        {4'h5, 1'b1, 32'hFFFF0000}, {4'h5, 1'b0, 32'h0000FFFF},
        {4'h2, 1'b0, 32'h80017FFE}, {4'h2, 1'b1, 32'h00C3A596}};
    b3216_bridge i_dut (.*);
    b3216_copro_model i_model (.*);
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Strobes held until ready, per the hand-over order
    // Single words only, never bursts
    task automatic xfer(logic w, logic [31:0] d);
        int n;
        logic [7:0] h0;
        logic [4:0] seen;
        h0 = halves;
        seen = 5'h00;
        @(negedge ref_clk);
        {address_strobe_n, data_enable_strobe_n, copro_select} = 3'b001;
        write_not_read = w;
        host_wdata = d;
        rd_word = d;
        n = 0;
        @(negedge ref_clk);
        while (host_ready_n !== 1'b0 && n < 300) begin
            // Latch, low and high copro enables, both host enables, select
            seen |= {low_latch_clk, low_half_to_copro_en, high_half_to_copro_en,
                     low_half_to_host_en && high_half_to_host_en,
                     !copro_cs_n && copro_mem_sel};
            @(negedge ref_clk);
            n++;
        end
        check("ready", host_ready_n, 1'b0);
        {address_strobe_n, data_enable_strobe_n, copro_select} = 3'b110;
        @(negedge ref_clk);
        check("halves", halves - h0, 8'h02);
        check("addr1", got_a1, 2'b10);
        check("dir", to_copro_dir, w);
        if (w) check("wens", seen, 5'h0D);
        else check("rens", seen, 5'h13);
        if (w) check("wword", got_word, d);
        else check("rword", host_rdata, d);
    endtask
    initial begin
        rst = 1'b1;
        {address_strobe_n, data_enable_strobe_n, copro_select, write_not_read} = 4'hC;
        byte_en_n = 4'h0;
        busy_cyc = 4'h0;
        host_wdata = 32'h00000000;
        rd_word = 32'h00000000;
        repeat (2) @(negedge ref_clk);
        check("idle", {host_ready_n, copro_cs_n, copro_rd_n, copro_wr_n}, 4'hF);
        rst = 1'b0;
        foreach (rows[i]) begin
            busy_cyc = rows[i][36:33];
            xfer(rows[i][32], rows[i][31:0]);
        end
        // Reset while the command count runs, then a clean access
        @(negedge ref_clk);
        {address_strobe_n, data_enable_strobe_n, copro_select} = 3'b001;
        repeat (2) @(negedge ref_clk);
        rst = 1'b1;
        {address_strobe_n, data_enable_strobe_n, copro_select} = 3'b110;
        repeat (2) @(negedge ref_clk);
        check("rstidle", {host_ready_n, copro_cs_n, copro_rd_n, copro_wr_n}, 4'hF);
        rst = 1'b0;
        // Odd-only byte lanes: address bit zero set, upper byte enabled
        byte_en_n = 4'h5;
        @(negedge ref_clk);
        check("oddaddr", {addr0, upper_byte_enable_n}, 2'b10);
        xfer(1'b1, 32'h96A5C33C);
        xfer(1'b0, 32'h3C3CC3C3);
        give_verdict();
    end
    initial begin
        #100000;
        fail_count++;
        give_verdict();
    end
endmodule
